// File: src/freq_counter_pkg.sv
package freq_counter_pkg;

  localparam int NUM_CHAN = 8;
  localparam int TICK_W = 24;
  localparam int PERIOD_W = 18;
  localparam int WIN_W = 10;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_WINDOW = 12'h004;
  localparam logic [11:0] OFS_ARM = 12'h008;
  localparam logic [11:0] OFS_HEALTH = 12'h00c;
  localparam logic [11:0] OFS_COUPLING = 12'h010;
  localparam logic [11:0] OFS_OVF = 12'h014;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h01c;
  localparam logic [11:0] OFS_IRQ_EN = 12'h020;
  localparam logic [5:0] OFS_TABLE_BLK = 6'h01;

  // Field positions in the control register.
  localparam int CTRL_CONT_BIT = 0;
  localparam int CTRL_FAST_BIT = 1;

  // Values after reset.
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [WIN_W-1:0] WINDOW_RST = 10'h009;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // Clock and timebase.
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_SLOW_HZ = 1_000_000;
  localparam int TICK_FAST_HZ = 10_000_000;
  localparam int WINDOW_STEP_MS = 1;
  localparam int PRESC_SLOW = CLK_HZ / TICK_SLOW_HZ;
  localparam int PRESC_FAST = CLK_HZ / TICK_FAST_HZ;
  localparam logic [7:0] PRESC_SLOW_MAX = 8'(PRESC_SLOW - 1);
  localparam logic [7:0] PRESC_FAST_MAX = 8'(PRESC_FAST - 1);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CH_IDLE, CH_WAIT_EDGE, CH_COUNT} chan_e;

  typedef struct packed {
    logic [TICK_W-1:0] ticks;
    logic [PERIOD_W-1:0] periods;
  } result_s;

  typedef struct packed {
    logic fast;
    logic cont;
  } ctrl_s;

endpackage : freq_counter_pkg

// File: src/freq_counter.sv
// Functional notes
// - Channel counts only after arm, from first edge.
// - One window setting shared by all channels.
// - Window programmable from 1 ms to 1.024 s.
// - Window setting steps in 1 ms units.
// - Store 24-bit ticks and 18-bit periods per window.
// - Long period keeps window open until one period.
// - Latest-result table readable anytime, newest values.
// - Single-scan or continuous mode, software selected.
// - Timebase tick selectable 1 MHz or 10 MHz.
// - Lowest frequency 0.06 Hz slow, 0.6 Hz fast.
// - Per-channel overflow flag below measurable limit.
// - Software switches channel input to health-check input.
// - Tick counter overflow sets maskable interrupt source.
// - Interrupt when any unmasked source bit set.
// - Host reaches results in memory space, 32/16-bit.
// - Per-channel AC or DC coupling setting held.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module freq_counter
  import freq_counter_pkg::*;
#(
  parameter int SLOW_TICKS_PER_MS = 1000,
  parameter int FAST_TICKS_PER_MS = 10000
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire logic [NUM_CHAN-1:0] CHAN_I,
  input wire logic HEALTH_I,
  input wire logic [11:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [11:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output logic [NUM_CHAN-1:0] COUPLING_AC_O,
  output logic IRQ_O
);

  localparam logic [TICK_W-1:0] TICK_MAX = {TICK_W{1'b1}};
  localparam logic [PERIOD_W-1:0] PERIOD_MAX = {PERIOD_W{1'b1}};
  localparam logic [TICK_W-1:0] SLOW_PER_MS = TICK_W'(SLOW_TICKS_PER_MS * WINDOW_STEP_MS);
  localparam logic [TICK_W-1:0] FAST_PER_MS = TICK_W'(FAST_TICKS_PER_MS * WINDOW_STEP_MS);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge

  // Bus-side registers.
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Software-visible state.
  ctrl_s ctrl_q;
  logic [WIN_W-1:0] window_q;
  logic [NUM_CHAN-1:0] health_q;
  logic [NUM_CHAN-1:0] coupling_q;
  logic [NUM_CHAN-1:0] irq_stat_q;
  logic [NUM_CHAN-1:0] irq_en_q;
  logic irq_q;

  // Timebase.
  logic [7:0] presc_q;
  logic tick_q;

  // Per-channel views gathered from the generate loop.
  result_s result_w [NUM_CHAN];
  logic [NUM_CHAN-1:0] ovf_flag_w;
  logic [NUM_CHAN-1:0] ovf_evt_w;
  logic [NUM_CHAN-1:0] busy_w;

  // Write decode: the write happens once both address and data are held.
  wire wr_en = ~awready_q & ~wready_q & ~bvalid_q;
  wire wr_ctrl = wr_en & (awaddr_q == OFS_CTRL);
  wire wr_window = wr_en & (awaddr_q == OFS_WINDOW);
  wire wr_arm = wr_en & (awaddr_q == OFS_ARM) & wstrb_q[0];
  wire wr_health = wr_en & (awaddr_q == OFS_HEALTH);
  wire wr_coupling = wr_en & (awaddr_q == OFS_COUPLING);
  wire wr_irq_clr = wr_en & (awaddr_q == OFS_IRQ_CLR) & wstrb_q[0];
  wire wr_irq_en = wr_en & (awaddr_q == OFS_IRQ_EN);
  wire wr_table = awaddr_q[11:6] == OFS_TABLE_BLK;
  wire wr_ro = (awaddr_q == OFS_OVF) | (awaddr_q == OFS_IRQ_STAT) | wr_table;
  wire wr_hit = (awaddr_q == OFS_CTRL) | (awaddr_q == OFS_WINDOW) | (awaddr_q == OFS_ARM) |
                (awaddr_q == OFS_HEALTH) | (awaddr_q == OFS_COUPLING) | (awaddr_q == OFS_IRQ_CLR) |
                (awaddr_q == OFS_IRQ_EN) | wr_ro;
  // Each stored register merges the held write data into its own current value, byte by byte; arm and interrupt clear act on byte 0 alone.
  wire [31:0] ctrl_m = merge({30'h0, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] window_m = merge({22'h0, window_q}, wdata_q, wstrb_q);
  wire [31:0] health_m = merge({24'h0, health_q}, wdata_q, wstrb_q);
  wire [31:0] coupling_m = merge({24'h0, coupling_q}, wdata_q, wstrb_q);
  wire [31:0] irq_en_m = merge({24'h0, irq_en_q}, wdata_q, wstrb_q);
  wire [NUM_CHAN-1:0] arm_w = wr_arm ? wdata_q[NUM_CHAN-1:0] : '0;
  wire [NUM_CHAN-1:0] irq_clr_w = wr_irq_clr ? wdata_q[NUM_CHAN-1:0] : '0;

  // Read decode from the live read address; the table answers at any time.
  wire rd_table = AXI_ARADDR_I[11:6] == OFS_TABLE_BLK;
  wire [2:0] rd_ch = AXI_ARADDR_I[5:3];
  wire result_s rd_res = result_w[rd_ch];
  wire [31:0] rd_table_word = AXI_ARADDR_I[2] ? {14'h0, rd_res.periods} : {8'h00, rd_res.ticks};
  wire rd_hit_reg = (AXI_ARADDR_I == OFS_CTRL) | (AXI_ARADDR_I == OFS_WINDOW) |
                    (AXI_ARADDR_I == OFS_ARM) | (AXI_ARADDR_I == OFS_HEALTH) |
                    (AXI_ARADDR_I == OFS_COUPLING) | (AXI_ARADDR_I == OFS_OVF) |
                    (AXI_ARADDR_I == OFS_IRQ_STAT) | (AXI_ARADDR_I == OFS_IRQ_CLR) |
                    (AXI_ARADDR_I == OFS_IRQ_EN);
  wire [31:0] rd_reg_word =
    (AXI_ARADDR_I == OFS_CTRL) ? {30'h0, ctrl_q} :
    (AXI_ARADDR_I == OFS_WINDOW) ? {22'h0, window_q} :
    (AXI_ARADDR_I == OFS_ARM) ? {24'h0, busy_w} :
    (AXI_ARADDR_I == OFS_HEALTH) ? {24'h0, health_q} :
    (AXI_ARADDR_I == OFS_COUPLING) ? {24'h0, coupling_q} :
    (AXI_ARADDR_I == OFS_OVF) ? {24'h0, ovf_flag_w} :
    (AXI_ARADDR_I == OFS_IRQ_STAT) ? {24'h0, irq_stat_q} :
    (AXI_ARADDR_I == OFS_IRQ_EN) ? {24'h0, irq_en_q} : 32'h0;
  wire rd_hit = rd_hit_reg | rd_table;
  wire [31:0] rd_word = rd_table ? rd_table_word : rd_reg_word;

  // Window length in ticks: setting n means n+1 milliseconds, 1 ms to 1.024 s.
  wire [TICK_W-1:0] win_ms = TICK_W'(window_q) + 24'h000001;
  wire [TICK_W-1:0] win_ticks = TICK_W'(win_ms * (ctrl_q.fast ? FAST_PER_MS : SLOW_PER_MS));
  wire [7:0] presc_max = ctrl_q.fast ? PRESC_FAST_MAX : PRESC_SLOW_MAX;
  wire [NUM_CHAN-1:0] irq_stat_d = (irq_stat_q & ~irq_clr_w) | ovf_evt_w;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (CE_I) begin
      if (AXI_AWVALID_I && awready_q) begin
        awaddr_q <= {AXI_AWADDR_I[11:2], 2'h0};
        awready_q <= 1'b0;
      end
      if (AXI_WVALID_I && wready_q) begin
        wdata_q <= AXI_WDATA_I;
        wstrb_q <= AXI_WSTRB_I;
        wready_q <= 1'b0;
      end
      if (wr_en) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_hit && !wr_ro) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0;
    end else if (CE_I) begin
      if (AXI_ARVALID_I && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && AXI_RREADY_I) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Byte strobes allow 16-bit and 32-bit writes of every writable register.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= CTRL_RST;
      window_q <= WINDOW_RST;
      health_q <= BYTE_RST;
      coupling_q <= BYTE_RST;
      irq_en_q <= BYTE_RST;
      irq_stat_q <= BYTE_RST;
      irq_q <= 1'b0;
    end else if (CE_I) begin
      if (wr_ctrl) ctrl_q <= ctrl_m[1:0];
      if (wr_window) window_q <= window_m[WIN_W-1:0];
      if (wr_health) health_q <= health_m[7:0];
      if (wr_coupling) coupling_q <= coupling_m[7:0];
      if (wr_irq_en) irq_en_q <= irq_en_m[7:0];
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_en_q);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      presc_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (CE_I) begin
      tick_q <= presc_q >= presc_max;
      presc_q <= (presc_q >= presc_max) ? 8'h00 : presc_q + 8'h01;
    end
  end

  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    chan_e st_q;
    logic prev_q;
    logic ovf_q;
    logic evt_q;
    logic [TICK_W-1:0] ticks_q;
    logic [PERIOD_W-1:0] per_q;
    result_s res_q;

    wire in_w = health_q[g] ? HEALTH_I : CHAN_I[g];
    wire edge_w = in_w & ~prev_q;
    wire tick_ovf_w = tick_q & (ticks_q == TICK_MAX);
    wire [PERIOD_W-1:0] per_inc_w = (per_q == PERIOD_MAX) ? PERIOD_MAX : per_q + 18'h00001;
    wire [TICK_W-1:0] ticks_inc_w = tick_q ? ticks_q + 24'h000001 : ticks_q;
    // The tick of the closing cycle counts, so a window that elapses exactly on an edge closes there.
    wire win_done_w = ticks_inc_w >= win_ticks;

    assign result_w[g] = res_q;
    assign ovf_flag_w[g] = ovf_q;
    assign ovf_evt_w[g] = evt_q;
    assign busy_w[g] = st_q != CH_IDLE;

    always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
        st_q <= CH_IDLE;
        prev_q <= 1'b0;
        ovf_q <= 1'b0;
        evt_q <= 1'b0;
        ticks_q <= '0;
        per_q <= '0;
        res_q <= '0;
      end else if (CE_I) begin
        prev_q <= in_w;
        evt_q <= 1'b0;
        case (st_q)
          CH_IDLE: begin
            if (arm_w[g]) st_q <= CH_WAIT_EDGE;
          end
          CH_WAIT_EDGE: begin
            if (edge_w) begin
              st_q <= CH_COUNT;
              ticks_q <= '0;
              per_q <= '0;
            end
          end
          CH_COUNT: begin
            if (tick_ovf_w) begin
              ovf_q <= 1'b1;
              evt_q <= 1'b1;
              res_q <= '{ticks: TICK_MAX, periods: per_q};
              st_q <= ctrl_q.cont ? CH_WAIT_EDGE : CH_IDLE;
            end else if (edge_w && win_done_w) begin
              // Closing only on an edge keeps whole periods and at least one of them.
              res_q <= '{ticks: ticks_inc_w, periods: per_inc_w};
              ovf_q <= 1'b0;
              ticks_q <= '0;
              per_q <= '0;
              st_q <= ctrl_q.cont ? CH_COUNT : CH_IDLE;
            end else begin
              ticks_q <= ticks_inc_w;
              if (edge_w) per_q <= per_inc_w;
            end
          end
          default: st_q <= CH_IDLE;
        endcase
      end
    end
  end

  assign AXI_AWREADY_O = awready_q;
  assign AXI_WREADY_O = wready_q;
  assign AXI_BVALID_O = bvalid_q;
  assign AXI_BRESP_O = bresp_q;
  assign AXI_ARREADY_O = arready_q;
  assign AXI_RVALID_O = rvalid_q;
  assign AXI_RRESP_O = rresp_q;
  assign AXI_RDATA_O = rdata_q;
  assign COUPLING_AC_O = coupling_q;
  assign IRQ_O = irq_q;

endmodule : freq_counter

// File: tb/freq_counter_monitor.sv
`timescale 1ns/1ps
module freq_counter_monitor
  import freq_counter_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [11:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  input wire logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  input wire logic AXI_WREADY_O,
  input wire logic [1:0] AXI_BRESP_O,
  input wire logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [11:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  input wire logic AXI_ARREADY_O,
  input wire logic [31:0] AXI_RDATA_O,
  input wire logic [1:0] AXI_RRESP_O,
  input wire logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  input wire logic [NUM_CHAN-1:0] COUPLING_AC_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  wire wr_go = AXI_AWVALID_I && AXI_AWREADY_O && AXI_WVALID_I && AXI_WREADY_O;
  wire rd_go = AXI_ARVALID_I && AXI_ARREADY_O;
  wire cpl_go = wr_go && AXI_AWADDR_I[11:2] == OFS_COUPLING[11:2] && AXI_WSTRB_I[0];
  property p_wresp; wr_go |=> !AXI_AWREADY_O && !AXI_WREADY_O ##1 AXI_BVALID_O; endproperty
  a_wresp: assert property (p_wresp) else $error("write answer late");
  property p_bdone; AXI_BVALID_O && AXI_BREADY_I |=> !AXI_BVALID_O && AXI_AWREADY_O; endproperty
  a_bdone: assert property (p_bdone) else $error("write answer stuck");
  property p_rresp; rd_go |=> AXI_RVALID_O && !AXI_ARREADY_O; endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_rdone; AXI_RVALID_O && AXI_RREADY_I |=> !AXI_RVALID_O && AXI_ARREADY_O; endproperty
  a_rdone: assert property (p_rdone) else $error("read answer stuck");
  property p_hole; rd_go && AXI_ARADDR_I[11:2] == 10'h009 |=> AXI_RRESP_O == RESP_SLVERR && AXI_RDATA_O == 32'h0;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read accepted");
  property p_ro; wr_go && AXI_AWADDR_I[11:2] == OFS_OVF[11:2] |-> ##2 AXI_BRESP_O == RESP_SLVERR; endproperty
  a_ro: assert property (p_ro) else $error("flag write accepted");
  property p_cpl; cpl_go |-> ##2 COUPLING_AC_O == $past(AXI_WDATA_I[NUM_CHAN-1:0], 2); endproperty
  a_cpl: assert property (p_cpl) else $error("coupling not updated");
  property p_cpl_hold; $changed(COUPLING_AC_O) |-> $past(cpl_go, 2); endproperty
  a_cpl_hold: assert property (p_cpl_hold) else $error("coupling changed alone");
  c_write: cover property (wr_go);
  c_read: cover property (rd_go);
  c_err: cover property (AXI_RVALID_O && AXI_RRESP_O == RESP_SLVERR);
endmodule : freq_counter_monitor

bind freq_counter freq_counter_monitor i_mon (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .AXI_AWADDR_I(AXI_AWADDR_I),
  .AXI_AWVALID_I(AXI_AWVALID_I), .AXI_AWREADY_O(AXI_AWREADY_O), .AXI_WDATA_I(AXI_WDATA_I),
  .AXI_WSTRB_I(AXI_WSTRB_I), .AXI_WVALID_I(AXI_WVALID_I), .AXI_WREADY_O(AXI_WREADY_O), .AXI_BRESP_O(AXI_BRESP_O),
  .AXI_BVALID_O(AXI_BVALID_O), .AXI_BREADY_I(AXI_BREADY_I), .AXI_ARADDR_I(AXI_ARADDR_I),
  .AXI_ARVALID_I(AXI_ARVALID_I), .AXI_ARREADY_O(AXI_ARREADY_O), .AXI_RDATA_O(AXI_RDATA_O),
  .AXI_RRESP_O(AXI_RRESP_O), .AXI_RVALID_O(AXI_RVALID_O), .AXI_RREADY_I(AXI_RREADY_I),
  .COUPLING_AC_O(COUPLING_AC_O));

// File: tb/pulse_source.sv
`timescale 1ns/1ps
module pulse_source (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] period_i [9],
  output logic [8:0] line_o
);
  logic [15:0] cnt_q [9];
  // Each line rises when its counter wraps, so rising edges are exactly one period apart.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 9; i++) begin
      cnt_q[i] <= (rst_i || cnt_q[i] >= period_i[i] - 16'h1) ? 16'h0 : cnt_q[i] + 16'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      line_o[i] = cnt_q[i] < (period_i[i] >> 1);
    end
  end
endmodule : pulse_source

// File: tb/tb_eight_channel_frequency_counter.sv
`timescale 1ns/1ps
module tb_eight_channel_frequency_counter import freq_counter_pkg::*;;
  typedef struct packed {
    logic [1:0] ctrl;
    logic [9:0] win;
    logic [15:0] per;
    logic [23:0] ticks;
    logic [17:0] periods;
  } row_s;
  // Periods are whole multiples of the tick spacing, so every period holds a fixed number of ticks.
  row_s rows [5] = '{'{2'h0, 10'h0, 16'h1f4, 24'h2, 18'h1},
    '{2'h0, 10'h2, 16'h1f4, 24'h6, 18'h3},
    '{2'h2, 10'h0, 16'h32, 24'h4, 18'h2},
    '{2'h0, 10'h0, 16'h5dc, 24'h6, 18'h1},
    '{2'h2, 10'h1, 16'hfa, 24'ha, 18'h1}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [7:0] coupling;
  logic [8:0] lines;
  logic [15:0] period [9] = '{default: 16'h1f4};
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  freq_counter #(.SLOW_TICKS_PER_MS(2), .FAST_TICKS_PER_MS(4)) i_dut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1),
    .CHAN_I(lines[7:0]), .HEALTH_I(lines[8]), .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
    .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
    .AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
    .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready), .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp),
    .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready), .COUPLING_AC_O(coupling), .IRQ_O(irq));
  pulse_source i_src (.clk_i(clk), .rst_i(rst), .period_i(period), .line_o(lines));
  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wait_idle(input logic [7:0] m);
    do rd(OFS_ARM);
    while ((d[7:0] & m) !== 8'h0);
  endtask : wait_idle
  task automatic measure(input row_s x, input logic [7:0] m);
    wr(OFS_CTRL, {30'h0, x.ctrl});
    wr(OFS_WINDOW, {22'h0, x.win});
    for (int i = 0; i < 8; i++) period[i] <= x.per;
    wr(OFS_ARM, {24'h0, m});
    wait_idle(m);
  endtask : measure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Pulses run from reset on, yet nothing may be stored before an arm.
    repeat (1200) @(posedge clk);
    rd(OFS_CTRL);
    chk("ctrl", d, 32'h0);
    rd(OFS_WINDOW);
    chk("window", d, 32'h9);
    rd(12'h040);
    chk("ticks0", d, 32'h0);
    rd(OFS_ARM);
    chk("busy", d, 32'h0);
    foreach (rows[k]) begin
      measure(rows[k], 8'hff);
      for (int c = 0; c < 8; c++) begin
        rd(12'h040 + 12'(8 * c));
        chk("ticks", d, {8'h0, rows[k].ticks});
        rd(12'h044 + 12'(8 * c));
        chk("periods", d, {14'h0, rows[k].periods});
      end
    end
    rd(OFS_OVF);
    chk("ovf", d, 32'h0);
    wr(OFS_HEALTH, 32'h08);
    period[8] <= 16'h5dc;
    measure(rows[0], 8'h0c);
    rd(12'h058);
    chk("health", d, 32'h6);
    rd(12'h050);
    chk("normal", d, 32'h2);
    wr(OFS_HEALTH, 32'h0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_ARM, 32'h1);
    repeat (3000) @(posedge clk);
    rd(OFS_ARM);
    chk("cont", d, 32'h1);
    rd(12'h044);
    chk("cont_per", d, 32'h1);
    wr(OFS_CTRL, 32'h0);
    wait_idle(8'h01);
    wr(OFS_COUPLING, 32'ha5);
    rd(OFS_COUPLING);
    chk("coupling", {24'h0, coupling}, 32'ha5);
    chk("coupling_rd", d, 32'ha5);
    wstrb <= 4'hc;
    wr(OFS_COUPLING, 32'h0);
    chk("d16_resp", {30'h0, r}, {30'h0, RESP_OKAY});
    chk("d16", {24'h0, coupling}, 32'ha5);
    wstrb <= 4'hf;
    wr(OFS_IRQ_EN, 32'hff);
    rd(OFS_IRQ_EN);
    chk("irq_en", d, 32'hff);
    wr(OFS_IRQ_CLR, 32'hff);
    rd(OFS_IRQ_STAT);
    chk("irq_stat", d, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(12'h024);
    chk("hole", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFS_OVF, 32'hff);
    chk("ro", {30'h0, r}, {30'h0, RESP_SLVERR});
    // A reset in mid-run must bring every setting back to its value after reset.
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk("rst_cpl", {24'h0, coupling}, 32'h0);
    rd(OFS_WINDOW);
    chk("rst_window", d, 32'h9);
    rd(OFS_IRQ_EN);
    chk("rst_irq_en", d, 32'h0);
    end_of_test();
  end
endmodule : tb_eight_channel_frequency_counter
